// [rtl/bfms_cfg.svh]
// timing counts, register offsets and field positions of the bridge fault supervisor
`ifndef BFMS_CFG_SVH
`define BFMS_CFG_SVH
`define BFMS_CLK_MHZ          200
`define BFMS_WAKE_US          1000
`define BFMS_WAKE_CYC         (`BFMS_WAKE_US * `BFMS_CLK_MHZ)
`define BFMS_SLEEP_US         1
`define BFMS_SLEEP_CYC        (`BFMS_SLEEP_US * `BFMS_CLK_MHZ)
`define BFMS_RETRY_US         1000
`define BFMS_RETRY_CYC        (`BFMS_RETRY_US * `BFMS_CLK_MHZ)
`define BFMS_OLSETTLE_US      50
`define BFMS_OLSETTLE_CYC     (`BFMS_OLSETTLE_US * `BFMS_CLK_MHZ)
`define BFMS_PWRUP_US         10
`define BFMS_PWRUP_CYC        (`BFMS_PWRUP_US * `BFMS_CLK_MHZ)
`define BFMS_CNT_W            20
`define BFMS_REG_CTRL         4'h0
`define BFMS_REG_STATUS       4'h4
`define BFMS_REG_IRQ_STAT     4'h8
`define BFMS_REG_IRQ_MASK     4'hc
`define BFMS_CTRL_POLICY      0
`define BFMS_CTRL_REGIF       1
`define BFMS_CTRL_IFMODE_LO   2
`define BFMS_EV_UV            0
`define BFMS_EV_OC            1
`define BFMS_EV_OL            2
`define BFMS_EV_TSD           3
`define BFMS_EV_WAKE          4
`define BFMS_EV_W             5
`endif

// [rtl/bfms_pkg.sv]
// types of the bridge fault supervisor
package bfms_pkg;
  typedef enum logic [1:0] {
    bfms_if_four = 2'h0,
    bfms_if_two  = 2'h1,
    bfms_if_par  = 2'h2,
    bfms_if_ind  = 2'h3
  } bfms_ifmode_t;
  typedef enum logic [2:0] {
    bfms_st_pwrup = 3'h0,
    bfms_st_wake  = 3'h1,
    bfms_st_run   = 3'h3,
    bfms_st_tosl  = 3'h2,
    bfms_st_sleep = 3'h6
  } bfms_state_t;
  typedef struct packed {
    logic       uv;
    logic [3:0] oc;
    logic       thermal_shutdown_fault;
    logic [3:0] ls_cmp;
    logic [3:0] hs_cmp;
  } bfms_sense_t;
  typedef struct packed {
    logic [3:0] half_hiz;
    logic       circuits_on;
  } bfms_drive_t;
endpackage

// [rtl/bfms_top.sv]
// sleep, open-load and fault supervisor for a dual h-bridge, with axi4-lite registers
// Notes on behaviour
// RULE_01: low-side comparator high means open load
// RULE_02: high-side comparator high means open load
// RULE_03: sleep disables circuits, all outputs hi-z
// RULE_04: wake automatically; host waits wake delay
// RULE_05: fault pin pulses low at power-up
// RULE_06: wait sleep entry delay before sleeping
// RULE_07: four faults enter fault, flag pin
// RULE_08: undervoltage: all hi-z, circuits off, auto
// RULE_09: overcurrent hi-z per interface, retry delay
// RULE_10: plain variant: open load keeps bridge running
// RULE_11: open load cleared by power or sleep
// RULE_12: register variant uses policy bit
// RULE_13: overtemperature: both bridges hi-z until cool
// RULE_14: policy 0 runs, 1 forces hi-z
// RULE_15: diagnostic at power-up and wake edge
// RULE_16: open load latches fault pin low
// RULE_17: sample comparators after settle, before wake
// RULE_18: hi-z wins over running
//
// Implementation choices: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ps
`include "bfms_cfg.svh"
module bfms_top
  import bfms_pkg::*;
#(
  parameter int WAKE_CYC    = `BFMS_WAKE_CYC,
  parameter int SLEEP_CYC   = `BFMS_SLEEP_CYC,
  parameter int RETRY_CYC   = `BFMS_RETRY_CYC,
  parameter int SETTLE_CYC  = `BFMS_OLSETTLE_CYC,
  parameter int PWRUP_CYC   = `BFMS_PWRUP_CYC
) (
  input  wire logic        clock,
  input  wire logic        reset,
  input  wire logic        sleep_request_pin,
  input  wire bfms_sense_t sense_in,
  input  wire logic        tsd_cool,
  output bfms_drive_t      drive_q,
  output logic [3:0]       ol_pullup_q,
  output logic [3:0]       ol_pulldown_q,
  output logic             fault_flag_pin_n_q,
  output logic             irq_q,
  input  wire logic [3:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [3:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);
  localparam logic [`BFMS_CNT_W-1:0] WAKE_N   = WAKE_CYC[`BFMS_CNT_W-1:0];
  localparam logic [`BFMS_CNT_W-1:0] SLEEP_N  = SLEEP_CYC[`BFMS_CNT_W-1:0];
  localparam logic [`BFMS_CNT_W-1:0] RETRY_N  = RETRY_CYC[`BFMS_CNT_W-1:0];
  localparam logic [`BFMS_CNT_W-1:0] SETTLE_N = SETTLE_CYC[`BFMS_CNT_W-1:0];
  localparam logic [`BFMS_CNT_W-1:0] PWRUP_N  = PWRUP_CYC[`BFMS_CNT_W-1:0];

  // two-flop synchronisers for every pin-level input
  logic        slp_m_q, slp_s_q, slp_prev_q;
  bfms_sense_t sns_m_q, sns_s_q;
  logic        cool_m_q, cool_s_q;
  always_ff @(posedge clock) begin
    if (reset) begin
      slp_m_q    <= 1'b1; // idle level of the pin, so no false wake edge
      slp_s_q    <= 1'b1;
      slp_prev_q <= 1'b1;
      sns_m_q    <= '0;
      sns_s_q    <= '0;
      cool_m_q   <= 1'b1;
      cool_s_q   <= 1'b1;
    end else begin
      slp_m_q    <= sleep_request_pin;
      slp_s_q    <= slp_m_q;
      slp_prev_q <= slp_s_q;
      sns_m_q    <= sense_in;
      sns_s_q    <= sns_m_q;
      cool_m_q   <= tsd_cool;
      cool_s_q   <= cool_m_q;
    end
  end
  logic slp_rise;
  assign slp_rise = slp_s_q & ~slp_prev_q;

  // software controls
  logic         policy_q;
  logic         regif_q;
  bfms_ifmode_t ifmode_q;
  logic [`BFMS_EV_W-1:0] irq_stat_q, irq_mask_q;

  // mode sequencer and its timer
  bfms_state_t           state_q;
  logic [`BFMS_CNT_W-1:0] tmr_q;
  logic                  diag_pending_q;
  always_ff @(posedge clock) begin
    if (reset) begin
      state_q <= bfms_st_pwrup;
      tmr_q   <= '0;
    end else begin
      unique case (state_q)
        bfms_st_pwrup: begin
          tmr_q <= tmr_q + 1'b1;
          if (tmr_q >= PWRUP_N - 1'b1) begin
            state_q <= bfms_st_wake; // RULE_15
            tmr_q   <= '0;
          end
        end
        bfms_st_wake: begin
          tmr_q <= tmr_q + 1'b1;
          if (tmr_q >= WAKE_N - 1'b1) begin
            state_q <= bfms_st_run; // RULE_04
            tmr_q   <= '0;
          end
        end
        bfms_st_run: begin
          if (!slp_s_q) begin
            state_q <= bfms_st_tosl;
            tmr_q   <= '0;
          end
        end
        bfms_st_tosl: begin
          tmr_q <= tmr_q + 1'b1;
          if (slp_s_q) begin
            state_q <= bfms_st_run;
          end else if (tmr_q >= SLEEP_N - 1'b1) begin
            state_q <= bfms_st_sleep; // RULE_06
          end
        end
        bfms_st_sleep: begin
          if (slp_rise) begin
            state_q <= bfms_st_wake; // RULE_04 RULE_15
            tmr_q   <= '0;
          end
        end
        default: begin
          state_q <= bfms_st_pwrup;
          tmr_q   <= '0;
        end
      endcase
    end
  end

  // open-load diagnostic: drive test currents during wake, sample once settled
  logic       in_wake, ol_sample;
  logic [3:0] ol_hit;
  assign in_wake   = (state_q == bfms_st_wake);
  assign ol_sample = in_wake && diag_pending_q && (tmr_q == SETTLE_N); // RULE_17
  assign ol_hit    = (ol_pulldown_q & sns_s_q.ls_cmp)                  // RULE_01
                   | (ol_pullup_q & sns_s_q.hs_cmp);                   // RULE_02
  logic [3:0] ol_lat_q;
  always_ff @(posedge clock) begin
    if (reset) begin
      ol_lat_q       <= '0;
      diag_pending_q <= 1'b1;
      ol_pullup_q    <= '0;
      ol_pulldown_q  <= '0;
    end else begin
      if (state_q == bfms_st_sleep && slp_rise) begin
        ol_lat_q       <= '0; // RULE_11
        diag_pending_q <= 1'b1;
      end else if (ol_sample) begin
        ol_lat_q       <= ol_hit; // RULE_16
        diag_pending_q <= 1'b0;
      end
      // even outputs pulled down (supply loads), odd pulled up (ground loads)
      ol_pulldown_q <= (in_wake && diag_pending_q) ? 4'h5 : 4'h0; // RULE_01
      ol_pullup_q   <= (in_wake && diag_pending_q) ? 4'ha : 4'h0; // RULE_02
    end
  end

  // overcurrent latch per half-bridge, released after the retry delay
  logic [3:0] oc_lat_q;
  logic [`BFMS_CNT_W-1:0] retry_q;
  always_ff @(posedge clock) begin
    if (reset) begin
      oc_lat_q <= '0;
      retry_q  <= '0;
    end else if (|oc_lat_q) begin
      retry_q <= retry_q + 1'b1;
      if (retry_q >= RETRY_N - 1'b1) begin
        oc_lat_q <= sns_s_q.oc; // RULE_09
        retry_q  <= '0;
      end
    end else begin
      oc_lat_q <= sns_s_q.oc;
    end
  end

  // thermal fault holds until the hysteresis comparator reports cool
  logic tsd_q;
  always_ff @(posedge clock) begin
    if (reset) begin
      tsd_q <= 1'b0;
    end else if (sns_s_q.thermal_shutdown_fault) begin
      tsd_q <= 1'b1; // RULE_13
    end else if (cool_s_q) begin
      tsd_q <= 1'b0;
    end
  end

  // map each fault to the half-bridges it disables
  function automatic logic [3:0] bfms_span(input logic [3:0] hit, input bfms_ifmode_t m);
    logic [3:0] r;
    r = hit;
    unique case (m)
      bfms_if_ind:  r = hit;
      bfms_if_par:  r = (|hit) ? 4'hf : 4'h0;
      default:      r = {{2{|hit[3:2]}}, {2{|hit[1:0]}}};
    endcase
    return r;
  endfunction

  logic [3:0] oc_hiz, ol_hiz, hiz_all;
  logic       asleep, uv;
  assign asleep  = (state_q == bfms_st_sleep) || (state_q == bfms_st_pwrup);
  assign uv      = sns_s_q.uv;
  assign oc_hiz  = bfms_span(oc_lat_q, ifmode_q); // RULE_09
  // plain variant keeps running on open load; register variant obeys policy
  assign ol_hiz  = (regif_q && policy_q) ? bfms_span(ol_lat_q, ifmode_q) // RULE_12 RULE_14
                                         : 4'h0;                         // RULE_10
  assign hiz_all = {4{asleep | uv | tsd_q}} | oc_hiz | ol_hiz;          // RULE_18 RULE_03 RULE_08

  // bridge drive and fault pin
  logic any_fault;
  assign any_fault = uv | (|oc_lat_q) | (|ol_lat_q) | tsd_q; // RULE_07
  always_ff @(posedge clock) begin
    if (reset) begin
      drive_q.half_hiz    <= 4'hf;
      drive_q.circuits_on <= 1'b0;
      fault_flag_pin_n_q  <= 1'b0;
    end else begin
      drive_q.half_hiz    <= hiz_all;
      drive_q.circuits_on <= ~(asleep | uv); // RULE_03 RULE_08
      fault_flag_pin_n_q  <= ~(any_fault | (state_q == bfms_st_pwrup)); // RULE_05 RULE_16
    end
  end

  // axi4-lite slave, one access of each kind at a time
  logic [3:0]  aw_q;
  logic [31:0] w_q;
  logic [3:0]  ws_q;
  logic        aw_have_q, w_have_q;
  logic        wr_go;
  assign wr_go = aw_have_q && w_have_q && !s_axi_bvalid;
  always_ff @(posedge clock) begin
    if (reset) begin
      aw_have_q     <= 1'b0;
      w_have_q      <= 1'b0;
      aw_q          <= '0;
      w_q           <= '0;
      ws_q          <= '0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'h0;
    end else begin
      s_axi_awready <= !aw_have_q && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready  <= !w_have_q && !(s_axi_wvalid && s_axi_wready);
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_q <= 1'b1;
        aw_q      <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_q <= 1'b1;
        w_q      <= s_axi_wdata;
        ws_q     <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_have_q    <= 1'b0;
        w_have_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (aw_q == `BFMS_REG_CTRL || aw_q == `BFMS_REG_IRQ_STAT
                      || aw_q == `BFMS_REG_IRQ_MASK) ? 2'h0 : 2'h2;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // register writes and sticky event bits; a new event beats a clear
  logic [`BFMS_EV_W-1:0] ev;
  logic [`BFMS_EV_W-1:0] clr;
  logic                  lane0;
  assign lane0 = wr_go && ws_q[0];
  assign ev = {(state_q == bfms_st_wake) && (tmr_q >= WAKE_N - 1'b1), tsd_q & ~cool_s_q,
               |(ol_sample ? ol_hit : 4'h0), |sns_s_q.oc, uv};
  assign clr = (lane0 && aw_q == `BFMS_REG_IRQ_STAT) ? w_q[`BFMS_EV_W-1:0] : '0;
  always_ff @(posedge clock) begin
    if (reset) begin
      policy_q   <= 1'b0;
      regif_q    <= 1'b0;
      ifmode_q   <= bfms_if_four;
      irq_stat_q <= '0;
      irq_mask_q <= '0;
      irq_q      <= 1'b0;
    end else begin
      if (lane0 && aw_q == `BFMS_REG_CTRL) begin
        policy_q <= w_q[`BFMS_CTRL_POLICY]; // RULE_14
        regif_q  <= w_q[`BFMS_CTRL_REGIF];
        ifmode_q <= bfms_ifmode_t'(w_q[`BFMS_CTRL_IFMODE_LO +: 2]);
      end
      if (lane0 && aw_q == `BFMS_REG_IRQ_MASK) begin
        irq_mask_q <= w_q[`BFMS_EV_W-1:0];
      end
      irq_stat_q <= (irq_stat_q & ~clr) | ev;
      irq_q      <= |(irq_stat_q & ~irq_mask_q); // a set mask bit blocks its event
    end
  end

  // read channel
  logic [31:0] rd_d;
  always_comb begin
    rd_d = '0;
    unique case (s_axi_araddr)
      `BFMS_REG_CTRL:     rd_d = {28'h0, ifmode_q, regif_q, policy_q};
      `BFMS_REG_STATUS:   rd_d = {19'h0, state_q, ol_lat_q, oc_lat_q, tsd_q, uv};
      `BFMS_REG_IRQ_STAT: rd_d = {27'h0, irq_stat_q};
      `BFMS_REG_IRQ_MASK: rd_d = {27'h0, irq_mask_q};
      default:            rd_d = '0;
    endcase
  end
  always_ff @(posedge clock) begin
    if (reset) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= 2'h0;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_d;
        s_axi_rresp  <= (s_axi_araddr[1:0] == 2'h0 && s_axi_araddr <= `BFMS_REG_IRQ_MASK)
                      ? 2'h0 : 2'h2;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule

// [verification/bfms_monitor.sv]
// port assertions for the bridge fault supervisor
`timescale 1ns/1ps
module bfms_monitor
  import bfms_pkg::*;
#(
  parameter int SLEEP_CYC = 8
) (
  input wire logic        clock,
  input wire logic        reset,
  input wire logic        sleep_request_pin,
  input wire bfms_sense_t sense_in,
  input wire bfms_drive_t drive_q,
  input wire logic [3:0]  ol_pullup_q,
  input wire logic [3:0]  ol_pulldown_q,
  input wire logic        fault_flag_pin_n_q,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid
);
  int low_q;
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  // cycles that the sleep request has been held low
  always_ff @(posedge clock) begin
    if (reset || sleep_request_pin) begin
      low_q <= 0;
    end else if (low_q < 1000) begin
      low_q <= low_q + 1;
    end
  end
  // wake edge followed by the test currents
  sequence s_wake_edge;
    $rose(sleep_request_pin) ##1 sleep_request_pin [*4];
  endsequence
  sequence s_diag_on;
    ##[0:6] (ol_pulldown_q == 4'h5 && ol_pullup_q == 4'ha);
  endsequence
  // fault, sleep and handshake relations
  a_uv_shutdown: assert property (sense_in.uv [*6] |-> drive_q == 5'h1e)
    else $error("undervoltage left the bridge driven");
  a_uv_flag: assert property (sense_in.uv [*6] |-> !fault_flag_pin_n_q)
    else $error("undervoltage not flagged");
  a_tsd_hiz: assert property (sense_in.thermal_shutdown_fault [*6] |-> drive_q.half_hiz == 4'hf)
    else $error("overtemperature left the bridge driven");
  a_sleep_hiz: assert property (low_q > SLEEP_CYC + 6 |-> drive_q == 5'h1e)
    else $error("sleep not entered");
  a_sleep_wait: assert property ($fell(sleep_request_pin) && drive_q.circuits_on
    && !sense_in.uv |=> drive_q.circuits_on [*8])
    else $error("sleep entered too early");
  a_pwrup_pulse: assert property ($fell(reset) |-> !fault_flag_pin_n_q [*4])
    else $error("no power-up pulse on fault pin");
  a_test_pattern: assert property (ol_pullup_q != 4'h0 || ol_pulldown_q != 4'h0
    |-> ol_pullup_q == 4'ha && ol_pulldown_q == 4'h5)
    else $error("test current pattern wrong");
  a_wake_diag: assert property (s_wake_edge |-> s_diag_on)
    else $error("no diagnostic after wake");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
endmodule

// [verification/bfms_host.sv]
// host controller model: drives the sleep request and waits out the wake delay
`timescale 1ns/1ps
module bfms_host #(
  parameter int WAKE_CYC = 64
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic want_sleep,
  output logic     sleep_request_pin,
  output logic     awake
);
  int   wait_q;
  logic pin_q;
  // pin follows the request; the wake delay is counted from the rising edge
  always_ff @(posedge clock) begin
    if (reset) begin
      pin_q <= 1'b1;
      wait_q <= 0;
    end else begin
      pin_q <= !want_sleep;
      wait_q <= want_sleep ? 0 : (wait_q > WAKE_CYC + 24 ? wait_q : wait_q + 1);
    end
  end
  assign sleep_request_pin = pin_q;
  assign awake = wait_q > WAKE_CYC + 24;
endmodule

// [verification/test_bridge_fault_mode_supervisor.sv]
// self-checking bench for the bridge fault supervisor
`timescale 1ns/1ps
module test_bridge_fault_mode_supervisor
  import bfms_pkg::*;
;
  localparam int WAKE = 64;
  localparam int SLP = 8;
  localparam int RETRY = 32;
  localparam logic [31:0] CTRL_T [3] = '{32'hf, 32'h1, 32'h6};
  localparam logic [3:0] LS_T [3] = '{4'h1, 4'h0, 4'ha};
  localparam logic [3:0] HS_T [3] = '{4'h0, 4'h2, 4'h5};
  localparam logic [3:0] HIZ_T [3] = '{4'h1, 4'h0, 4'h0};
  localparam logic [3:0] LAT_T [3] = '{4'h1, 4'h2, 4'h0};
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic want_sleep = 1'b0;
  logic tsd_cool = 1'b0;
  logic sleep_request_pin, awake, fault_flag_pin_n_q, irq_q;
  bfms_sense_t sense_in = '0;
  bfms_drive_t drive_q;
  logic [3:0] ol_pullup_q, ol_pulldown_q, s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
  logic [1:0] s_axi_bresp, s_axi_rresp, rr, br;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [15:0] lf = 16'h0033;
  int n_errors = 0;
  int total_checks = 0;
  bfms_top #(.WAKE_CYC(WAKE), .SLEEP_CYC(SLP), .RETRY_CYC(RETRY), .SETTLE_CYC(16),
    .PWRUP_CYC(8)) dut (.clock, .reset, .sleep_request_pin, .sense_in, .tsd_cool, .drive_q,
    .ol_pullup_q, .ol_pulldown_q, .fault_flag_pin_n_q, .irq_q, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  bfms_host #(.WAKE_CYC(WAKE)) host (.clock, .reset, .want_sleep, .sleep_request_pin, .awake);
  // free-running clock
  initial begin
    forever #2.5 clock = ~clock;
  end
  // helpers: waiting, comparing, random source, expected overcurrent span
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  function automatic logic [15:0] lfsr(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  function automatic logic [3:0] oc_span(input int m, input logic [1:0] h);
    case (m)
      2: return 4'hf;
      3: return 4'h1 << h;
      default: return h[1] ? 4'hc : 4'h3;
    endcase
  endfunction
  // register bus master: each channel held until its own ready
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d);
    int t;
    @(posedge clock);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
    t = 0;
    do begin
      @(posedge clock);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      br = s_axi_bresp;
      t++;
    end while (!s_axi_bvalid && t < 100);
    s_axi_bready <= 1'b0;
    check(t < 100, 1'b1);
  endtask
  task automatic axi_rd(input logic [3:0] a);
    int t;
    @(posedge clock);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'b11;
    t = 0;
    do begin
      @(posedge clock);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      rd = s_axi_rdata;
      rr = s_axi_rresp;
      t++;
    end while (!s_axi_rvalid && t < 100);
    s_axi_rready <= 1'b0;
    check(t < 100, 1'b1);
  endtask
  task automatic wait_awake;
    int t;
    t = 0;
    while (!awake && t < 1000) begin
      @(posedge clock);
      t++;
    end
    check(awake, 1'b1);
  endtask
  task automatic wrap_up;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // hang guard
  initial begin
    #100000;
    n_errors++;
    wrap_up;
  end
  // main sequence
  initial begin
    tick(10);
    reset <= 1'b0;
    tick(2);
    check(fault_flag_pin_n_q, 1'b0);
    wait_awake;
    axi_rd(4'h4);
    check(rd[12:10], 3'h3);
    check(fault_flag_pin_n_q, 1'b1);
    axi_rd(4'h2);
    check(rr, 2'h2);
    axi_wr(4'h4, 32'h0);
    check(br, 2'h2);
    axi_wr(4'hc, 32'h0);
    check(br, 2'h0);
    axi_wr(4'h8, 32'h1f);
    sense_in.uv <= 1'b1;
    tick(8);
    check(drive_q, 5'h1e);
    check(fault_flag_pin_n_q, 1'b0);
    check(irq_q, 1'b1);
    axi_wr(4'hc, 32'h1);
    tick(2);
    check(irq_q, 1'b0);
    sense_in.uv <= 1'b0;
    tick(8);
    check(drive_q.circuits_on, 1'b1);
    axi_wr(4'h8, 32'h1f);
    axi_wr(4'hc, 32'h0);
    axi_rd(4'h8);
    check(rd[0], 1'b0);
    for (int m = 0; m < 4; m++) begin
      lf = lfsr(lf);
      axi_wr(4'h0, {28'h0, m[1:0], lf[2], 1'b0});
      axi_rd(4'h0);
      check(rd, {28'h0, m[1:0], lf[2], 1'b0});
      sense_in.oc <= 4'h1 << lf[1:0];
      tick(8);
      check(drive_q.half_hiz, oc_span(m, lf[1:0]));
      check(drive_q.circuits_on, 1'b1);
      sense_in.oc <= 4'h0;
      tick(2 * RETRY + 8);
      check(drive_q.half_hiz, 4'h0);
    end
    sense_in.thermal_shutdown_fault <= 1'b1;
    tick(8);
    check(drive_q.half_hiz, 4'hf);
    sense_in.thermal_shutdown_fault <= 1'b0;
    tick(8);
    check(drive_q.half_hiz, 4'hf);
    tsd_cool <= 1'b1;
    tick(8);
    check(drive_q.half_hiz, 4'h0);
    tsd_cool <= 1'b0;
    for (int k = 0; k < 3; k++) begin
      axi_wr(4'h0, CTRL_T[k]);
      want_sleep <= 1'b1;
      tick(SLP + 10);
      check(drive_q, 5'h1e);
      sense_in.ls_cmp <= LS_T[k];
      sense_in.hs_cmp <= HS_T[k];
      want_sleep <= 1'b0;
      wait_awake;
      check(drive_q.half_hiz, HIZ_T[k]);
      check(fault_flag_pin_n_q, k == 2);
      axi_rd(4'h4);
      check(rd[9:6], LAT_T[k]);
    end
    wrap_up;
  end
endmodule
bind bfms_top bfms_monitor #(.SLEEP_CYC(SLEEP_CYC)) mon (.clock, .reset, .sleep_request_pin,
  .sense_in, .drive_q, .ol_pullup_q, .ol_pulldown_q, .fault_flag_pin_n_q, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rvalid);
